// File: inc/dfr_pkg.sv
package dfr_pkg;
	localparam int          WIDE_W        = 36;
	localparam int          NARROW_W      = 18;
	localparam int          OFFSET_W      = 10;
	localparam int          FIFO_N        = 2;
	// reset must span this many clock edges inside the device
	localparam logic [2:0]  RST_MIN_EDGES = 3'h4;
	// write clocks from reset release to input-ready high
	localparam logic [1:0]  READY_DELAY   = 2'h2;
	// edges the host keeps the byte-order level after its release
	localparam logic [2:0]  SEL_SWAP      = 3'h3;
	localparam logic [OFFSET_W-1:0] OFFSET_CLEAR = 10'h000;
	// reset index layout in the synchroniser bank
	localparam int          IDX_F1_FULL   = 0;
	localparam int          IDX_F2_FULL   = 1;
	localparam int          IDX_F1_PART   = 2;
	localparam int          IDX_F2_PART   = 3;
	typedef enum logic [1:0] {DFR_IDLE, DFR_FULL, DFR_WAIT, DFR_RUN} dfr_host_e;
endpackage : dfr_pkg

// File: inc/dfr_if.sv
`timescale 1ns/1ps
interface dfr_if;
	import dfr_pkg::*;
	// resets and straps from the far side
	logic                fifo1_full_reset_n;
	logic                fifo2_full_reset_n;
	logic                fifo1_partial_reset_n;
	logic                fifo2_partial_reset_n;
	logic                byte_order_timing_select;
	logic                offset_select_low;
	logic                offset_select_high;
	logic                serial_program_select_n;
	// port controls
	logic                wide_mailbox_select;
	logic                transmit_mailbox_select;
	logic                receive_mailbox_select;
	logic                wide_chip_select_n;
	logic                transmit_chip_select_n;
	logic                wide_write_read_select;
	logic                wide_enable;
	logic                transmit_read_enable;
	logic                receive_write_enable;
	logic [NARROW_W-1:0] receive_data;
	// wide two-way bus: both drivers, resolved below
	logic [WIDE_W-1:0]   wide_dev_out;
	logic                wide_dev_oe;
	logic [WIDE_W-1:0]   wide_host_out;
	logic                wide_host_oe;
	logic [WIDE_W-1:0]   wide_bus;
	logic [NARROW_W-1:0] transmit_data;
	logic                transmit_data_oe;
	// flags
	logic                wide_full_or_input_ready;
	logic                receive_full_or_input_ready;
	logic                wide_empty_or_output_ready;
	logic                transmit_empty_or_output_ready;
	logic                wide_almost_empty;
	logic                transmit_almost_empty;
	logic                wide_almost_full;
	logic                receive_almost_full;
	logic                mailbox_one_full_n;
	logic                mailbox_two_full_n;

	// undriven bus reads as zero
	assign wide_bus = wide_dev_oe ? wide_dev_out : (wide_host_oe ? wide_host_out : '0);

	modport dev (
		input  fifo1_full_reset_n, fifo2_full_reset_n, fifo1_partial_reset_n,
		input  fifo2_partial_reset_n, byte_order_timing_select, offset_select_low,
		input  offset_select_high, serial_program_select_n, wide_mailbox_select,
		input  transmit_mailbox_select, receive_mailbox_select, wide_chip_select_n,
		input  transmit_chip_select_n, wide_write_read_select, wide_enable,
		input  transmit_read_enable, receive_write_enable, receive_data, wide_bus,
		output wide_dev_out, wide_dev_oe, transmit_data, transmit_data_oe,
		output wide_full_or_input_ready, receive_full_or_input_ready,
		output wide_empty_or_output_ready, transmit_empty_or_output_ready,
		output wide_almost_empty, transmit_almost_empty, wide_almost_full,
		output receive_almost_full, mailbox_one_full_n, mailbox_two_full_n
	);
	modport host (
		output fifo1_full_reset_n, fifo2_full_reset_n, fifo1_partial_reset_n,
		output fifo2_partial_reset_n, byte_order_timing_select, offset_select_low,
		output offset_select_high, serial_program_select_n, wide_mailbox_select,
		output transmit_mailbox_select, receive_mailbox_select, wide_chip_select_n,
		output transmit_chip_select_n, wide_write_read_select, wide_enable,
		output transmit_read_enable, receive_write_enable, receive_data,
		output wide_host_out, wide_host_oe,
		input  wide_bus, transmit_data, transmit_data_oe,
		input  wide_full_or_input_ready, receive_full_or_input_ready,
		input  wide_empty_or_output_ready, transmit_empty_or_output_ready,
		input  wide_almost_empty, transmit_almost_empty, wide_almost_full,
		input  receive_almost_full, mailbox_one_full_n, mailbox_two_full_n
	);
endinterface : dfr_if

// File: core/dfr_device.sv
// Overview of operation
// R1: far side pulses both full resets together first
// R2: full reset held low four edges per clock
// R3: partial reset held low four edges per clock
// R4: reset inputs synchronised inside, may be asynchronous
// R5: full reset clears pointers, forces all flags
// R6: full reset sets mailbox flag high
// R7: input-ready rises two write clocks after release
// R8: full reset release latches byte order, offset mode
// R9: second full reset release clears its offsets
// R10: receive mailbox select held high during reset
// R11: partial reset clears pointers, forces all flags
// R12: partial reset sets mailbox flag high
// R13: input-ready rises two clocks after partial release
// R14: partial reset keeps offsets, method, timing mode
// R15: mailbox flags fall on write, rise on read
// R16: mailbox write shows on enabled selected outputs
// R17: reset forces almost and mailbox flags immediately
// R18: wide outputs driven on select and read only
// R19: mailbox select switches outputs without clock
// R20: byte-order level at release picks endian order
// R21: level one edge after release picks timing
// R22: reset completes only after counted edges
`timescale 1ns/1ps
module dfr_device
	import dfr_pkg::*;
(
	// clock and reset
	input  wire logic                CLK,
	input  wire logic                RST_N,
	// link to the far side
	dfr_if.dev                       LINK,
	// latched configuration
	output logic                     BIG_ENDIAN,
	output logic [FIFO_N-1:0]        STANDARD_TIMING,
	output logic [2:0]               OFFSET_MODE,
	output logic [OFFSET_W-1:0]      FIFO2_AE_OFFSET,
	output logic [OFFSET_W-1:0]      FIFO2_AF_OFFSET
);

	logic [3:0]              rst_raw;
	logic [3:0]              rst_s1_ff;
	logic [3:0]              rst_s2_ff;
	logic [FIFO_N-1:0]       full_prev_ff;
	logic [FIFO_N-1:0]       act_prev_ff;
	logic [FIFO_N-1:0]       rst_act;
	logic [FIFO_N-1:0]       raw_ok;
	logic [FIFO_N-1:0]       full_rise;
	logic [FIFO_N-1:0]       timing_pend_ff;
	logic [2:0]              cnt_ff    [FIFO_N];
	logic [1:0]              dly_ff    [FIFO_N];
	logic [FIFO_N-1:0]       done_ff;
	logic [FIFO_N-1:0]       ready_ff;
	logic [FIFO_N-1:0]       mbf_ff;
	logic [WIDE_W-1:0]       mailbox_one_register_ff;
	logic [NARROW_W-1:0]     mailbox_two_register_ff;
	logic [FIFO_N-1:0]       mb_wr;
	logic [FIFO_N-1:0]       mb_rd;

	////////////////////////////////////////////////////////////////////////
	// reset synchronisers

	assign rst_raw = {LINK.fifo2_partial_reset_n, LINK.fifo1_partial_reset_n,
		LINK.fifo2_full_reset_n, LINK.fifo1_full_reset_n};

	// two flops; only the second stage feeds logic
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			rst_s1_ff <= 4'h0;
			rst_s2_ff <= 4'h0;
		end else begin
			rst_s1_ff <= rst_raw; // R4
			rst_s2_ff <= rst_s1_ff;
		end
	end

	// per-fifo reset views
	always_comb begin
		rst_act[0]   = ~rst_s2_ff[IDX_F1_FULL] | ~rst_s2_ff[IDX_F1_PART];
		rst_act[1]   = ~rst_s2_ff[IDX_F2_FULL] | ~rst_s2_ff[IDX_F2_PART];
		raw_ok[0]    = rst_raw[IDX_F1_FULL] & rst_raw[IDX_F1_PART];
		raw_ok[1]    = rst_raw[IDX_F2_FULL] & rst_raw[IDX_F2_PART];
		full_rise[0] = rst_s2_ff[IDX_F1_FULL] & ~full_prev_ff[0];
		full_rise[1] = rst_s2_ff[IDX_F2_FULL] & ~full_prev_ff[1];
	end

	////////////////////////////////////////////////////////////////////////
	// reset sequencing, one lane per fifo

	for (genvar i = 0; i < FIFO_N; i++) begin : g_lane
		// short pulses never complete, so after a glitch input-ready stays low until a full-length reset
		always_ff @(posedge CLK) begin
			if (!RST_N) begin
				cnt_ff[i]  <= 3'h0;
				done_ff[i] <= 1'b0;
			end else if (rst_act[i]) begin
				if (cnt_ff[i] != RST_MIN_EDGES)
					cnt_ff[i] <= cnt_ff[i] + 3'h1;
				done_ff[i] <= 1'b0;
			end else begin
				cnt_ff[i] <= 3'h0;
				if (act_prev_ff[i] && cnt_ff[i] == RST_MIN_EDGES)
					done_ff[i] <= 1'b1; // R22
			end
		end

		// input-ready after the release delay
		always_ff @(posedge CLK) begin
			if (!RST_N) begin
				dly_ff[i]   <= 2'h0;
				ready_ff[i] <= 1'b0;
			end else if (rst_act[i]) begin
				dly_ff[i]   <= 2'h0;
				ready_ff[i] <= 1'b0; // R5 R11
			end else if (done_ff[i] && !ready_ff[i]) begin
				dly_ff[i] <= dly_ff[i] + 2'h1;
				if (dly_ff[i] == READY_DELAY - 2'h1)
					ready_ff[i] <= 1'b1; // R7 R13
			end
		end

		// timing mode taken one edge after full release only
		always_ff @(posedge CLK) begin
			if (!RST_N) begin
				timing_pend_ff[i]  <= 1'b0;
				STANDARD_TIMING[i] <= 1'b1;
			end else begin
				timing_pend_ff[i] <= full_rise[i];
				if (timing_pend_ff[i])
					STANDARD_TIMING[i] <= LINK.byte_order_timing_select; // R21 R14
			end
		end

		// mailbox flag: write wins over a same-edge read
		always_ff @(posedge CLK) begin
			if (!RST_N)
				mbf_ff[i] <= 1'b1;
			else if (rst_act[i])
				mbf_ff[i] <= 1'b1; // R6 R12
			else if (mb_wr[i])
				mbf_ff[i] <= 1'b0; // R15
			else if (mb_rd[i])
				mbf_ff[i] <= 1'b1; // R15
		end
	end

	// edge history
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			full_prev_ff <= '0;
			act_prev_ff  <= '0;
		end else begin
			full_prev_ff <= {rst_s2_ff[IDX_F2_FULL], rst_s2_ff[IDX_F1_FULL]};
			act_prev_ff  <= rst_act;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// configuration latched at full-reset release

	// partial resets never touch these
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			BIG_ENDIAN  <= 1'b0;
			OFFSET_MODE <= 3'h0;
		end else if (|full_rise) begin
			BIG_ENDIAN  <= LINK.byte_order_timing_select; // R8 R20 R14
			OFFSET_MODE <= {LINK.offset_select_high, LINK.offset_select_low,
				LINK.serial_program_select_n}; // R8
		end
	end

	// offset loading itself lives elsewhere; only the clear is here
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			FIFO2_AE_OFFSET <= OFFSET_CLEAR;
			FIFO2_AF_OFFSET <= OFFSET_CLEAR;
		end else if (full_rise[1]) begin
			FIFO2_AE_OFFSET <= OFFSET_CLEAR; // R9
			FIFO2_AF_OFFSET <= OFFSET_CLEAR; // R9
		end
	end

	////////////////////////////////////////////////////////////////////////
	// mailboxes

	// port strobes; selects ignored while a lane is in reset
	always_comb begin
		mb_wr[0] = ~rst_act[0] & mbf_ff[0] & LINK.wide_mailbox_select & LINK.wide_enable
			& ~LINK.wide_chip_select_n & LINK.wide_write_read_select;
		mb_rd[0] = ~rst_act[0] & LINK.transmit_mailbox_select & LINK.transmit_read_enable
			& ~LINK.transmit_chip_select_n;
		mb_wr[1] = ~rst_act[1] & mbf_ff[1] & LINK.receive_mailbox_select
			& LINK.receive_write_enable;
		mb_rd[1] = ~rst_act[1] & LINK.wide_mailbox_select & LINK.wide_enable
			& ~LINK.wide_chip_select_n & ~LINK.wide_write_read_select;
	end

	// mailbox storage
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			mailbox_one_register_ff <= '0;
			mailbox_two_register_ff <= '0;
		end else begin
			if (mb_wr[0])
				mailbox_one_register_ff <= LINK.wide_bus; // R16
			if (mb_wr[1])
				mailbox_two_register_ff <= LINK.receive_data; // R16
		end
	end

	////////////////////////////////////////////////////////////////////////
	// port outputs; these paths are combinational on purpose since
	// select and reset changes must not wait for an edge

	// the fifo data path is outside this block, so fifo data reads as zero
	always_comb begin
		LINK.wide_dev_oe      = ~LINK.wide_chip_select_n & ~LINK.wide_write_read_select; // R18
		LINK.transmit_data_oe = ~LINK.transmit_chip_select_n; // R18
		LINK.wide_dev_out     = LINK.wide_mailbox_select
			? {{(WIDE_W-NARROW_W){1'b0}}, mailbox_two_register_ff} : '0; // R19 R16
		LINK.transmit_data    = LINK.transmit_mailbox_select
			? mailbox_one_register_ff[NARROW_W-1:0] : '0; // R19 R16
	end

	// flags; almost flags stay at their empty values without a data path
	always_comb begin
		LINK.wide_full_or_input_ready       = ready_ff[0];
		LINK.receive_full_or_input_ready    = ready_ff[1];
		LINK.wide_empty_or_output_ready     = 1'b0; // R5 R11
		LINK.transmit_empty_or_output_ready = 1'b0; // R5 R11
		LINK.transmit_almost_empty          = 1'b0 & raw_ok[0]; // R17
		LINK.wide_almost_empty              = 1'b0 & raw_ok[1]; // R17
		LINK.wide_almost_full               = 1'b1 | ~raw_ok[0]; // R17
		LINK.receive_almost_full            = 1'b1 | ~raw_ok[1]; // R17
		LINK.mailbox_one_full_n             = mbf_ff[0] | ~raw_ok[0]; // R17
		LINK.mailbox_two_full_n             = mbf_ff[1] | ~raw_ok[1]; // R17
	end

endmodule : dfr_device

// File: core/dfr_host.sv
`timescale 1ns/1ps
module dfr_host
	import dfr_pkg::*;
(
	// clock and reset
	input  wire logic                CLK,
	input  wire logic                RST_N,
	// link to the device
	dfr_if.host                      LINK,
	// user requests, one-cycle pulses
	input  wire logic                FULL_RESET_REQ,
	input  wire logic [FIFO_N-1:0]   PARTIAL_RESET_REQ,
	input  wire logic                MB1_WRITE_REQ,
	input  wire logic [WIDE_W-1:0]   MB1_WRITE_DATA,
	input  wire logic                MB2_READ_REQ,
	input  wire logic                MB1_READ_REQ,
	input  wire logic                MB2_WRITE_REQ,
	input  wire logic [NARROW_W-1:0] MB2_WRITE_DATA,
	// configuration levels applied at full reset
	input  wire logic                CFG_BIG_ENDIAN,
	input  wire logic                CFG_STANDARD_TIMING,
	input  wire logic [2:0]          CFG_OFFSET_MODE,
	// status
	output logic                     READY,
	output logic [FIFO_N-1:0]        PARTIAL_BUSY
);

	dfr_host_e           state_ff;
	logic [2:0]          cnt_ff;
	logic [2:0]          part_cnt_ff [FIFO_N];
	logic                idle_op;

	assign idle_op = (state_ff == DFR_RUN);

	////////////////////////////////////////////////////////////////////////
	// full reset sequence

	// both fifos reset together, as power-up demands
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			state_ff <= DFR_IDLE;
			cnt_ff   <= 3'h0;
		end else begin
			unique case (state_ff)
				DFR_IDLE: begin
					cnt_ff   <= 3'h0;
					state_ff <= DFR_FULL; // R1
				end
				DFR_FULL: begin
					cnt_ff <= cnt_ff + 3'h1;
					if (cnt_ff == RST_MIN_EDGES - 3'h1) begin
						cnt_ff   <= 3'h0;
						state_ff <= DFR_WAIT; // R2
					end
				end
				DFR_WAIT: begin
					if (cnt_ff != SEL_SWAP)
						cnt_ff <= cnt_ff + 3'h1;
					if (LINK.wide_full_or_input_ready && LINK.receive_full_or_input_ready)
						state_ff <= DFR_RUN;
				end
				DFR_RUN: begin
					if (FULL_RESET_REQ)
						state_ff <= DFR_IDLE;
				end
			endcase
		end
	end

	// reset pins and straps
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			LINK.fifo1_full_reset_n       <= 1'b0;
			LINK.fifo2_full_reset_n       <= 1'b0;
			LINK.byte_order_timing_select <= 1'b0;
			LINK.offset_select_low        <= 1'b0;
			LINK.offset_select_high       <= 1'b0;
			LINK.serial_program_select_n  <= 1'b0;
			LINK.receive_mailbox_select   <= 1'b1;
			READY                         <= 1'b0;
		end else begin
			LINK.fifo1_full_reset_n <= (state_ff == DFR_WAIT) || (state_ff == DFR_RUN);
			LINK.fifo2_full_reset_n <= (state_ff == DFR_WAIT) || (state_ff == DFR_RUN);
			// endian level held across the device's sync delay, then timing level
			LINK.byte_order_timing_select <= (state_ff == DFR_WAIT && cnt_ff == SEL_SWAP)
				|| state_ff == DFR_RUN ? CFG_STANDARD_TIMING : CFG_BIG_ENDIAN;
			{LINK.offset_select_high, LINK.offset_select_low,
				LINK.serial_program_select_n} <= CFG_OFFSET_MODE;
			LINK.receive_mailbox_select <= ~idle_op | MB2_WRITE_REQ; // R10
			READY <= idle_op;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// partial resets

	for (genvar i = 0; i < FIFO_N; i++) begin : g_part
		always_ff @(posedge CLK) begin
			if (!RST_N)
				part_cnt_ff[i] <= 3'h0;
			else if (part_cnt_ff[i] != 3'h0)
				part_cnt_ff[i] <= part_cnt_ff[i] - 3'h1;
			else if (idle_op && PARTIAL_RESET_REQ[i])
				part_cnt_ff[i] <= RST_MIN_EDGES; // R3
		end
	end

	// partial reset pins
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			LINK.fifo1_partial_reset_n <= 1'b1;
			LINK.fifo2_partial_reset_n <= 1'b1;
			PARTIAL_BUSY               <= '0;
		end else begin
			LINK.fifo1_partial_reset_n <= (part_cnt_ff[0] == 3'h0);
			LINK.fifo2_partial_reset_n <= (part_cnt_ff[1] == 3'h0);
			PARTIAL_BUSY <= {part_cnt_ff[1] != 3'h0, part_cnt_ff[0] != 3'h0};
		end
	end

	////////////////////////////////////////////////////////////////////////
	// mailbox port cycles, one clock each

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			LINK.wide_chip_select_n      <= 1'b1;
			LINK.wide_write_read_select  <= 1'b1;
			LINK.wide_mailbox_select     <= 1'b0;
			LINK.wide_enable             <= 1'b0;
			LINK.wide_host_out           <= '0;
			LINK.wide_host_oe            <= 1'b0;
			LINK.transmit_chip_select_n  <= 1'b1;
			LINK.transmit_mailbox_select <= 1'b0;
			LINK.transmit_read_enable    <= 1'b0;
			LINK.receive_write_enable    <= 1'b0;
			LINK.receive_data            <= '0;
		end else begin
			// a write has priority over a read on the wide port
			LINK.wide_chip_select_n      <= ~(idle_op & (MB1_WRITE_REQ | MB2_READ_REQ));
			LINK.wide_write_read_select  <= ~idle_op | MB1_WRITE_REQ | ~MB2_READ_REQ;
			LINK.wide_mailbox_select     <= idle_op & (MB1_WRITE_REQ | MB2_READ_REQ);
			LINK.wide_enable             <= idle_op & (MB1_WRITE_REQ | MB2_READ_REQ);
			LINK.wide_host_oe            <= idle_op & MB1_WRITE_REQ;
			LINK.wide_host_out           <= MB1_WRITE_DATA;
			LINK.transmit_chip_select_n  <= ~(idle_op & MB1_READ_REQ);
			LINK.transmit_mailbox_select <= idle_op & MB1_READ_REQ;
			LINK.transmit_read_enable    <= idle_op & MB1_READ_REQ;
			LINK.receive_write_enable    <= idle_op & MB2_WRITE_REQ;
			LINK.receive_data            <= MB2_WRITE_DATA;
		end
	end

endmodule : dfr_host

// File: dv/dfr_properties.sv
`timescale 1ns/1ps
module dfr_properties (
	// clock and reset
	input wire logic CLK,
	input wire logic RST_N,
	// resets from the host
	input wire logic fifo1_full_reset_n,
	input wire logic fifo2_full_reset_n,
	input wire logic fifo1_partial_reset_n,
	input wire logic fifo2_partial_reset_n,
	// port controls
	input wire logic wide_chip_select_n,
	input wire logic wide_write_read_select,
	input wire logic wide_enable,
	input wire logic wide_mailbox_select,
	input wire logic transmit_chip_select_n,
	input wire logic transmit_read_enable,
	input wire logic transmit_mailbox_select,
	input wire logic receive_write_enable,
	input wire logic receive_mailbox_select,
	// device outputs
	input wire logic wide_dev_oe,
	input wire logic transmit_data_oe,
	input wire logic wide_full_or_input_ready,
	input wire logic receive_full_or_input_ready,
	input wire logic wide_almost_full,
	input wire logic receive_almost_full,
	input wire logic wide_almost_empty,
	input wire logic transmit_almost_empty,
	input wire logic mailbox_one_full_n,
	input wire logic mailbox_two_full_n
);
	logic f1_idle;
	logic f2_idle;

	// raw reset levels, no clock involved
	assign f1_idle = fifo1_full_reset_n & fifo1_partial_reset_n;
	assign f2_idle = fifo2_full_reset_n & fifo2_partial_reset_n;

	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_N);

	////////////////////////////////////////////////////////////////////////////////
	// mailbox steps; a same-edge write beats the read
	sequence s_mb1_wr;
		wide_enable && !wide_chip_select_n && wide_write_read_select && wide_mailbox_select
			&& wide_full_or_input_ready && f1_idle && mailbox_one_full_n;
	endsequence
	sequence s_mb1_rd;
		transmit_read_enable && !transmit_chip_select_n && transmit_mailbox_select && f1_idle
			&& wide_full_or_input_ready && !mailbox_one_full_n && !wide_enable;
	endsequence
	sequence s_mb2_wr;
		receive_write_enable && receive_mailbox_select && receive_full_or_input_ready
			&& f2_idle && mailbox_two_full_n;
	endsequence
	sequence s_mb2_rd;
		wide_enable && !wide_chip_select_n && !wide_write_read_select && wide_mailbox_select
			&& receive_full_or_input_ready && f2_idle && !mailbox_two_full_n && !receive_write_enable;
	endsequence

	////////////////////////////////////////////////////////////////////////////////
	a_mb1_write_clears: assert property (s_mb1_wr |=> !mailbox_one_full_n)
		else $error("mailbox one flag not low after write");
	a_mb1_read_sets: assert property (s_mb1_rd |=> mailbox_one_full_n)
		else $error("mailbox one flag not high after read");
	a_mb2_write_clears: assert property (s_mb2_wr |=> !mailbox_two_full_n)
		else $error("mailbox two flag not low after write");
	a_mb2_read_sets: assert property (s_mb2_rd |=> mailbox_two_full_n)
		else $error("mailbox two flag not high after read");
	a_reset_mbox_one: assert property (!f1_idle |-> mailbox_one_full_n && wide_almost_full
		&& !transmit_almost_empty)
		else $error("fifo one reset flags wrong");
	a_reset_mbox_two: assert property (!f2_idle |-> mailbox_two_full_n && receive_almost_full
		&& !wide_almost_empty)
		else $error("fifo two reset flags wrong");
	a_reset_drops_ready: assert property (!f1_idle [*4] |=> !wide_full_or_input_ready)
		else $error("fifo one ready high during reset");
	a_reset2_drops_ready: assert property (!f2_idle [*4] |=> !receive_full_or_input_ready)
		else $error("fifo two ready high during reset");
	a_ready_after_one: assert property ($rose(f1_idle) |-> ##[3:8] wide_full_or_input_ready)
		else $error("fifo one ready late after release");
	a_ready_after_two: assert property ($rose(f2_idle) |-> ##[3:8] receive_full_or_input_ready)
		else $error("fifo two ready late after release");
	a_ready_not_early: assert property ($rose(wide_full_or_input_ready) |-> $past(f1_idle, 3))
		else $error("fifo one ready rose too soon");
	a_wide_drive_rule: assert property (wide_dev_oe == (!wide_chip_select_n
		&& !wide_write_read_select))
		else $error("wide bus enable wrong");
	a_tx_drive_rule: assert property (transmit_data_oe == !transmit_chip_select_n)
		else $error("transmit enable wrong");
endmodule : dfr_properties

// File: dv/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	import dfr_pkg::*;
	logic                CLK, RST_N, full_req, mb1_wr, mb1_rd, mb2_wr, mb2_rd, cfg_be, cfg_std;
	logic [FIFO_N-1:0]   part_req, std_q, busy;
	logic [WIDE_W-1:0]   mb1_data, mb1_exp;
	logic [NARROW_W-1:0] mb2_data;
	logic [2:0]          cfg_mode, mode_q;
	logic [OFFSET_W-1:0] ae_q, af_q;
	logic                be_q, ready;
	int                  miscompares, comparisons, c;

	dfr_if u_dfr_if ();
	dfr_device u_dfr_device (.CLK(CLK), .RST_N(RST_N), .LINK(u_dfr_if), .BIG_ENDIAN(be_q),
		.STANDARD_TIMING(std_q), .OFFSET_MODE(mode_q), .FIFO2_AE_OFFSET(ae_q),
		.FIFO2_AF_OFFSET(af_q));
	dfr_host u_dfr_host (.CLK(CLK), .RST_N(RST_N), .LINK(u_dfr_if), .FULL_RESET_REQ(full_req),
		.PARTIAL_RESET_REQ(part_req), .MB1_WRITE_REQ(mb1_wr), .MB1_WRITE_DATA(mb1_data),
		.MB2_READ_REQ(mb2_rd), .MB1_READ_REQ(mb1_rd), .MB2_WRITE_REQ(mb2_wr),
		.MB2_WRITE_DATA(mb2_data), .CFG_BIG_ENDIAN(cfg_be), .CFG_STANDARD_TIMING(cfg_std),
		.CFG_OFFSET_MODE(cfg_mode), .READY(ready), .PARTIAL_BUSY(busy));
	dfr_properties u_dfr_properties (.CLK(CLK), .RST_N(RST_N),
		.fifo1_full_reset_n(u_dfr_if.fifo1_full_reset_n),
		.fifo2_full_reset_n(u_dfr_if.fifo2_full_reset_n),
		.fifo1_partial_reset_n(u_dfr_if.fifo1_partial_reset_n),
		.fifo2_partial_reset_n(u_dfr_if.fifo2_partial_reset_n),
		.wide_chip_select_n(u_dfr_if.wide_chip_select_n),
		.wide_write_read_select(u_dfr_if.wide_write_read_select),
		.wide_enable(u_dfr_if.wide_enable), .wide_mailbox_select(u_dfr_if.wide_mailbox_select),
		.transmit_chip_select_n(u_dfr_if.transmit_chip_select_n),
		.transmit_read_enable(u_dfr_if.transmit_read_enable),
		.transmit_mailbox_select(u_dfr_if.transmit_mailbox_select),
		.receive_write_enable(u_dfr_if.receive_write_enable),
		.receive_mailbox_select(u_dfr_if.receive_mailbox_select),
		.wide_dev_oe(u_dfr_if.wide_dev_oe), .transmit_data_oe(u_dfr_if.transmit_data_oe),
		.wide_full_or_input_ready(u_dfr_if.wide_full_or_input_ready),
		.receive_full_or_input_ready(u_dfr_if.receive_full_or_input_ready),
		.wide_almost_full(u_dfr_if.wide_almost_full),
		.receive_almost_full(u_dfr_if.receive_almost_full),
		.wide_almost_empty(u_dfr_if.wide_almost_empty),
		.transmit_almost_empty(u_dfr_if.transmit_almost_empty),
		.mailbox_one_full_n(u_dfr_if.mailbox_one_full_n),
		.mailbox_two_full_n(u_dfr_if.mailbox_two_full_n));

	////////////////////////////////////////////////////////////////////////////////
	// 10 MHz clock
	initial begin
		CLK = 1'b0;
		forever #50 CLK = ~CLK;
	end

	task end_of_test();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : end_of_test

	task chk(input string what, input logic [WIDE_W-1:0] exp, input logic [WIDE_W-1:0] got);
		comparisons++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	// one-cycle user strobe, released on the next edge so no re-entry clash
	task pulse(input int k);
		@(posedge CLK);
		case (k)
			0: full_req <= 1'b1;
			1: mb1_wr <= 1'b1;
			2: mb1_rd <= 1'b1;
			3: mb2_wr <= 1'b1;
			4: mb2_rd <= 1'b1;
			default: part_req <= FIFO_N'(k - 4);
		endcase
		@(posedge CLK);
		{full_req, mb1_wr, mb1_rd, mb2_wr, mb2_rd} <= 5'h00;
		part_req <= '0;
	endtask : pulse

	function automatic logic cond(input int k);
		case (k)
			0: return ready === 1'b1;
			1: return ready === 1'b0;
			2: return busy === '0;
			3: return u_dfr_if.transmit_data_oe === 1'b1 && u_dfr_if.transmit_mailbox_select === 1'b1;
			4: return u_dfr_if.wide_dev_oe === 1'b1 && u_dfr_if.wide_mailbox_select === 1'b1;
			5: return busy !== '0;
			6: return u_dfr_if.wide_full_or_input_ready === 1'b0;
			default: return u_dfr_if.receive_full_or_input_ready === 1'b0;
		endcase
	endfunction : cond

	// bounded wait; a hang ends the run
	task wait_on(input int k, input int n);
		int i;
		@(negedge CLK);
		for (i = 0; i < n && !cond(k); i++) @(negedge CLK);
		if (!cond(k)) begin
			miscompares++;
			$display("ERROR wait %0d expected 1 seen 0", k);
			end_of_test();
		end
	endtask : wait_on

	task chk_state(input logic r1, input logic r2, input logic m1, input logic m2);
		chk("ready one", WIDE_W'(r1), WIDE_W'(u_dfr_if.wide_full_or_input_ready));
		chk("ready two", WIDE_W'(r2), WIDE_W'(u_dfr_if.receive_full_or_input_ready));
		chk("mailbox one", WIDE_W'(m1), WIDE_W'(u_dfr_if.mailbox_one_full_n));
		chk("mailbox two", WIDE_W'(m2), WIDE_W'(u_dfr_if.mailbox_two_full_n));
		chk("big endian", WIDE_W'(c == 0), WIDE_W'(be_q));
		chk("timing", WIDE_W'({2{c == 1}}), WIDE_W'(std_q));
		chk("offset mode", WIDE_W'(c == 0 ? 3'h5 : 3'h2), WIDE_W'(mode_q));
		chk("offsets", '0, WIDE_W'({ae_q, af_q}));
		chk("empty", '0, WIDE_W'({u_dfr_if.wide_empty_or_output_ready,
			u_dfr_if.transmit_empty_or_output_ready}));
	endtask : chk_state

	////////////////////////////////////////////////////////////////////////////////
	// two full-reset configurations, each followed by mailbox and partial traffic
	initial begin
		{RST_N, full_req, mb1_wr, mb1_rd, mb2_wr, mb2_rd, cfg_std} = 7'h00;
		{part_req, mb1_data, mb2_data, miscompares, comparisons} = '0;
		cfg_be = 1'b1;
		cfg_mode = 3'h5;
		repeat (12) @(posedge CLK);
		RST_N <= 1'b1;
		for (c = 0; c < 2; c++) begin
			if (c == 1) begin
				cfg_be <= 1'b0;
				cfg_std <= 1'b1;
				cfg_mode <= 3'h2;
				pulse(0);
				wait_on(1, 20);
			end
			wait_on(0, 200);
			chk_state(1'b1, 1'b1, 1'b1, 1'b1);
			mb1_exp = c == 0 ? 36'h1_2345_abcd : 36'h9_8765_4321;
			mb1_data <= mb1_exp;
			pulse(1);
			mb1_data <= ~mb1_exp;
			pulse(1);
			chk_state(1'b1, 1'b1, 1'b0, 1'b1);
			pulse(2);
			wait_on(3, 4);
			chk("tx mailbox", WIDE_W'(mb1_exp[NARROW_W-1:0]), WIDE_W'(u_dfr_if.transmit_data));
			mb2_data <= mb1_exp[WIDE_W-1:WIDE_W-NARROW_W];
			pulse(3);
			repeat (2) @(negedge CLK);
			chk_state(1'b1, 1'b1, 1'b1, 1'b0);
			pulse(4);
			wait_on(4, 4);
			chk("wide mailbox", WIDE_W'(mb1_exp[WIDE_W-1:WIDE_W-NARROW_W]), u_dfr_if.wide_bus);
			repeat (2) @(negedge CLK);
			chk_state(1'b1, 1'b1, 1'b1, 1'b1);
			pulse(c == 0 ? 1 : 3);
			pulse(5 + c);
			wait_on(5, 10);
			wait_on(6 + c, 10);
			chk_state(c == 1, c == 0, 1'b1, 1'b1);
			wait_on(2, 100);
			repeat (10) @(negedge CLK);
			chk_state(1'b1, 1'b1, 1'b1, 1'b1);
		end
		end_of_test();
	end
endmodule : tb_top
